//--- design/rsx_alu.sv
// ahb-lite slave wrapping the rotate/subtract/swap/xor execute datapath
`timescale 1ns/10ps

module rsx_alu #(
    parameter int ADDR_W = 32
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic hsel,
    input wire logic [ADDR_W-1:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    output logic [7:0] portDir6,
    output logic [7:0] portDir7
);
    // register map needs eight address bits
    if (ADDR_W < 8)
    begin : g_bad_addr
        $error("ADDR_W below 8 cannot decode the register map");
    end

    // the reset image of the state record
    localparam rsx_pkg::rsx_state_type STATE_RST = '{
        fileRegs: '0,
        acc: rsx_pkg::ACC_RST,
        carry: 1'h0,
        dcarry: 1'h0,
        zero: 1'h0,
        dir6: rsx_pkg::DIR_RST,
        dir7: rsx_pkg::DIR_RST,
        wrPend: 1'h0,
        wrAddr: 8'h00,
        hrdata: 32'h0000_0000,
        hreadyout: 1'h1,
        hresp: rsx_pkg::HRESP_OKAY
    };

    rsx_pkg::rsx_state_type st_r; // registered state
    rsx_pkg::rsx_state_type st_nxt; // next state
    logic addrPhase; // address phase taken this edge
    logic execValid; // command word lands this cycle
    rsx_pkg::rsx_op_type cmdOp; // decoded opcode
    logic cmdDest; // 1 writes back to file register
    logic [4:0] cmdF; // file register operand
    logic [7:0] cmdK; // literal operand
    logic [7:0] fv; // selected file register value
    logic [8:0] diff9; // subtract with carry out
    logic [4:0] nib5; // low nibble subtract
    logic [7:0] res; // datapath result

    // only whole-word single transfers; hsize is accepted as is
    assign addrPhase = hsel && htrans == rsx_pkg::HTRANS_NONSEQ && hready;
    assign execValid = st_r.wrPend && st_r.wrAddr == rsx_pkg::CMD_OFFS;
    assign cmdOp = rsx_pkg::rsx_op_type'(hwdata[rsx_pkg::CMD_OP_LSB +: 3]);
    assign cmdDest = hwdata[rsx_pkg::CMD_DEST_BIT];
    assign cmdF = hwdata[rsx_pkg::CMD_F_LSB +: 5];
    assign cmdK = hwdata[rsx_pkg::CMD_K_LSB +: 8];
    assign fv = st_r.fileRegs[cmdF];
    // register minus accumulator by two's complement addition
    assign diff9 = {1'h0, fv} + {1'h0, ~st_r.acc} + 9'h001;
    assign nib5 = {1'h0, fv[3:0]} + {1'h0, ~st_r.acc[3:0]} + 5'h01;

    // read mux over a state image; unmapped words read zero
    function automatic logic [31:0] readWord(rsx_pkg::rsx_state_type s, logic [7:0] a);
        logic [31:0] w;
        w = 32'h0000_0000;
        if (a >= rsx_pkg::FILE_BASE && a[1:0] == 2'h0)
        begin
            w[7:0] = s.fileRegs[a[6:2]];
        end
        else
        begin
            unique case (a)
                rsx_pkg::ACC_OFFS: w[7:0] = s.acc;
                rsx_pkg::STATUS_OFFS:
                begin
                    w[rsx_pkg::CARRY_BIT] = s.carry;
                    w[rsx_pkg::DCARRY_BIT] = s.dcarry;
                    w[rsx_pkg::ZERO_BIT] = s.zero;
                end
                rsx_pkg::DIR6_OFFS: w[7:0] = s.dir6;
                rsx_pkg::DIR7_OFFS: w[7:0] = s.dir7;
                default: w = 32'h0000_0000;
            endcase
        end
        return w;
    endfunction

    // datapath result, pure function of operands
    always_comb
    begin
        res = 8'h00;
        unique case (cmdOp)
            rsx_pkg::OP_ROTL: res = {fv[6:0], st_r.carry};
            rsx_pkg::OP_ROTR: res = {st_r.carry, fv[7:1]};
            rsx_pkg::OP_SUB: res = diff9[7:0];
            rsx_pkg::OP_SWAP: res = {fv[3:0], fv[7:4]};
            rsx_pkg::OP_XORL: res = st_r.acc ^ cmdK;
            rsx_pkg::OP_XORF: res = st_r.acc ^ fv;
            default: res = 8'h00;
        endcase
    end

    // next state: data-phase write, then command execute, then capture next address
    always_comb
    begin
        st_nxt = st_r;
        if (st_r.wrPend)
        begin
            if (st_r.wrAddr >= rsx_pkg::FILE_BASE && st_r.wrAddr[1:0] == 2'h0)
            begin
                st_nxt.fileRegs[st_r.wrAddr[6:2]] = hwdata[7:0];
            end
            else if (st_r.wrAddr == rsx_pkg::ACC_OFFS)
            begin
                st_nxt.acc = hwdata[7:0];
            end
            else if (st_r.wrAddr == rsx_pkg::STATUS_OFFS)
            begin
                st_nxt.carry = hwdata[rsx_pkg::CARRY_BIT];
                st_nxt.dcarry = hwdata[rsx_pkg::DCARRY_BIT];
                st_nxt.zero = hwdata[rsx_pkg::ZERO_BIT];
            end
        end
        // writes to a command word run one instruction
        if (execValid)
        begin
            unique case (cmdOp)
                rsx_pkg::OP_ROTL, rsx_pkg::OP_ROTR, rsx_pkg::OP_SWAP,
                rsx_pkg::OP_SUB, rsx_pkg::OP_XORF:
                begin
                    // dest bit routes every file-register result
                    if (cmdDest)
                    begin
                        st_nxt.fileRegs[cmdF] = res;
                    end
                    else
                    begin
                        st_nxt.acc = res;
                    end
                    // carry for rotates and subtract
                    if (cmdOp == rsx_pkg::OP_ROTL)
                    begin
                        st_nxt.carry = fv[7];
                    end
                    else if (cmdOp == rsx_pkg::OP_ROTR)
                    begin
                        st_nxt.carry = fv[0];
                    end
                    else if (cmdOp == rsx_pkg::OP_SUB)
                    begin
                        // carry set means no borrow
                        st_nxt.carry = diff9[8];
                        st_nxt.dcarry = nib5[4];
                        st_nxt.zero = res == 8'h00;
                    end
                    else if (cmdOp == rsx_pkg::OP_XORF)
                    begin
                        st_nxt.zero = res == 8'h00;
                    end
                end
                rsx_pkg::OP_XORL:
                begin
                    st_nxt.acc = res;
                    st_nxt.zero = res == 8'h00;
                end
                rsx_pkg::OP_DIR:
                begin
                    // other operands are silently ignored
                    if (cmdF == rsx_pkg::DIR6_SEL)
                    begin
                        st_nxt.dir6 = st_r.acc;
                    end
                    else if (cmdF == rsx_pkg::DIR7_SEL)
                    begin
                        st_nxt.dir7 = st_r.acc;
                    end
                end
                default:
                begin
                    st_nxt.wrPend = st_r.wrPend;
                end
            endcase
        end
        st_nxt.wrPend = addrPhase && hwrite;
        st_nxt.wrAddr = addrPhase ? haddr[7:0] : 8'h00;
        // read from the post-write image so a read right after a write sees it
        st_nxt.hrdata = (addrPhase && !hwrite) ? readWord(st_nxt, haddr[7:0]) : 32'h0000_0000;
        // zero wait states, always okay
        st_nxt.hreadyout = 1'h1;
        st_nxt.hresp = rsx_pkg::HRESP_OKAY;
    end

    // single state register, synchronous reset
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            st_r <= STATE_RST;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    // outputs straight from the state record
    assign hreadyout = st_r.hreadyout;
    assign hrdata = st_r.hrdata;
    assign hresp = st_r.hresp;
    assign portDir6 = st_r.dir6;
    assign portDir7 = st_r.dir7;

    // checks on the executed instruction one edge after the command lands, and on read data one edge after its address phase
    chk_rotl_carry: assert property (@(posedge clk) disable iff (sys_rst)
        execValid && cmdOp == rsx_pkg::OP_ROTL && !cmdDest |=>
        st_r.acc == {$past(fv[6:0]), $past(st_r.carry)} && st_r.carry == $past(fv[7])
        && st_r.zero == $past(st_r.zero))
        else $error("rotate left result or carry wrong");
    chk_rotr_carry: assert property (@(posedge clk) disable iff (sys_rst)
        execValid && cmdOp == rsx_pkg::OP_ROTR && !cmdDest |=>
        st_r.acc == {$past(st_r.carry), $past(fv[7:1])} && st_r.carry == $past(fv[0])
        && st_r.dcarry == $past(st_r.dcarry))
        else $error("rotate right result or carry wrong");
    chk_dest_writeback: assert property (@(posedge clk) disable iff (sys_rst)
        execValid && cmdDest && cmdOp == rsx_pkg::OP_SWAP |=>
        st_r.fileRegs[$past(cmdF)] == {$past(fv[3:0]), $past(fv[7:4])}
        && st_r.acc == $past(st_r.acc))
        else $error("writeback to file register wrong");
    chk_sub_flags: assert property (@(posedge clk) disable iff (sys_rst)
        execValid && cmdOp == rsx_pkg::OP_SUB && !cmdDest |=>
        st_r.acc == $past(fv) - $past(st_r.acc)
        && st_r.carry == ($past(fv) >= $past(st_r.acc))
        && st_r.dcarry == ($past(fv[3:0]) >= $past(st_r.acc[3:0]))
        && st_r.zero == ($past(fv) == $past(st_r.acc)))
        else $error("subtract result or flags wrong");
    chk_swap_flags: assert property (@(posedge clk) disable iff (sys_rst)
        execValid && cmdOp == rsx_pkg::OP_SWAP && !cmdDest |=>
        st_r.acc == {$past(fv[3:0]), $past(fv[7:4])} && $stable(st_r.carry)
        && $stable(st_r.dcarry) && $stable(st_r.zero))
        else $error("nibble swap wrong or flags moved");
    chk_dir_load: assert property (@(posedge clk) disable iff (sys_rst)
        execValid && cmdOp == rsx_pkg::OP_DIR && cmdF == rsx_pkg::DIR6_SEL |=>
        portDir6 == $past(st_r.acc) && $stable(portDir7) && $stable(st_r.zero))
        else $error("direction load wrong");
    chk_xorf_zero: assert property (@(posedge clk) disable iff (sys_rst)
        execValid && cmdOp == rsx_pkg::OP_XORF && !cmdDest |=>
        st_r.acc == ($past(fv) ^ $past(st_r.acc)) && st_r.zero == ($past(fv) == $past(st_r.acc))
        && $stable(st_r.carry))
        else $error("register xor wrong");
    chk_xorl_acc: assert property (@(posedge clk) disable iff (sys_rst)
        execValid && cmdOp == rsx_pkg::OP_XORL |=>
        st_r.acc == ($past(cmdK) ^ $past(st_r.acc)) && $stable(st_r.carry))
        else $error("literal xor result wrong");
    chk_xorl_zero: assert property (@(posedge clk) disable iff (sys_rst)
        execValid && cmdOp == rsx_pkg::OP_XORL |=> st_r.zero == (st_r.acc == 8'h00))
        else $error("literal xor zero flag wrong");
    chk_read_zero_wait: assert property (@(posedge clk) disable iff (sys_rst)
        addrPhase && !hwrite && haddr[7:0] == rsx_pkg::DIR7_OFFS |=>
        hreadyout && hrdata == {24'h000000, portDir7})
        else $error("read data not in next cycle");
    // file-register destinations: the accumulator must stay put
    chk_rotl_file: assert property (@(posedge clk) disable iff (sys_rst)
        execValid && cmdOp == rsx_pkg::OP_ROTL && cmdDest |=>
        st_r.fileRegs[$past(cmdF)] == {$past(fv[6:0]), $past(st_r.carry)}
        && st_r.carry == $past(fv[7]) && $stable(st_r.acc))
        else $error("rotate left writeback wrong");
    chk_sub_file: assert property (@(posedge clk) disable iff (sys_rst)
        execValid && cmdOp == rsx_pkg::OP_SUB && cmdDest |=>
        st_r.fileRegs[$past(cmdF)] == $past(fv) - $past(st_r.acc)
        && st_r.carry == ($past(fv) >= $past(st_r.acc)) && $stable(st_r.acc))
        else $error("subtract writeback wrong");
    // literal form ignores the dest bit, so no file register may move
    chk_xorl_files: assert property (@(posedge clk) disable iff (sys_rst)
        execValid && cmdOp == rsx_pkg::OP_XORL |=> $stable(st_r.fileRegs) && $stable(st_r.dcarry))
        else $error("literal xor touched a file register or digit carry");

    // main scenarios
    cov_sub_borrow: cover property (@(posedge clk) disable iff (sys_rst)
        execValid && cmdOp == rsx_pkg::OP_SUB ##1 !st_r.carry);
    cov_rotl_file: cover property (@(posedge clk) disable iff (sys_rst)
        execValid && cmdOp == rsx_pkg::OP_ROTL && cmdDest);
    cov_xorf_zero: cover property (@(posedge clk) disable iff (sys_rst)
        execValid && cmdOp == rsx_pkg::OP_XORF ##1 st_r.zero);
    cov_dir7_load: cover property (@(posedge clk) disable iff (sys_rst)
        execValid && cmdOp == rsx_pkg::OP_DIR && cmdF == rsx_pkg::DIR7_SEL);
    cov_sub_file: cover property (@(posedge clk) disable iff (sys_rst)
        execValid && cmdOp == rsx_pkg::OP_SUB && cmdDest ##1 st_r.zero);
endmodule

//--- design/rsx_pkg.sv
// shared constants, opcode encoding and state record for the rotate/sub/swap/xor datapath
package rsx_pkg;
    // datapath widths
    localparam int DATA_W = 8;
    localparam int FILE_COUNT = 32;
    localparam int FILE_IDX_W = 5;
    // register byte offsets on the bus
    localparam logic [7:0] ACC_OFFS = 8'h00;
    localparam logic [7:0] STATUS_OFFS = 8'h04;
    localparam logic [7:0] CMD_OFFS = 8'h08;
    localparam logic [7:0] DIR6_OFFS = 8'h0C;
    localparam logic [7:0] DIR7_OFFS = 8'h10;
    localparam logic [7:0] FILE_BASE = 8'h80;
    // status register bit positions
    localparam int CARRY_BIT = 0;
    localparam int DCARRY_BIT = 1;
    localparam int ZERO_BIT = 2;
    // command word field positions
    localparam int CMD_OP_LSB = 0;
    localparam int CMD_DEST_BIT = 3;
    localparam int CMD_F_LSB = 4;
    localparam int CMD_K_LSB = 16;
    // direction-load operand values
    localparam logic [4:0] DIR6_SEL = 5'h06;
    localparam logic [4:0] DIR7_SEL = 5'h07;
    // ahb encodings
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic HRESP_OKAY = 1'h0;
    // reset values
    localparam logic [7:0] ACC_RST = 8'h00;
    localparam logic [7:0] DIR_RST = 8'hFF;

    // command opcodes; all eight codes are listed and OP_NONE does nothing
    typedef enum logic [2:0] {
        OP_NONE = 3'h0,
        OP_ROTL = 3'h1,
        OP_ROTR = 3'h2,
        OP_SUB = 3'h3,
        OP_SWAP = 3'h4,
        OP_DIR = 3'h5,
        OP_XORL = 3'h6,
        OP_XORF = 3'h7
    } rsx_op_type;

    // whole state of the block in one record
    typedef struct packed {
        logic [FILE_COUNT-1:0][DATA_W-1:0] fileRegs;
        logic [DATA_W-1:0] acc;
        logic carry;
        logic dcarry;
        logic zero;
        logic [DATA_W-1:0] dir6;
        logic [DATA_W-1:0] dir7;
        logic wrPend;
        logic [7:0] wrAddr;
        logic [31:0] hrdata;
        logic hreadyout;
        logic hresp;
    } rsx_state_type;
endpackage

//--- sim/rsx_master.sv
// bus master model standing in for the decoder and processor side of the bus
`timescale 1ns/10ps
module rsx_master (
    input wire logic clk,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    output logic hsel,
    output logic [31:0] haddr,
    output logic [1:0] htrans,
    output logic hwrite,
    output logic [2:0] hsize,
    output logic [31:0] hwdata
);
    // quiet bus at time zero, word transfers only
    initial
    begin
        hsel = 1'h0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'h0;
        hsize = 3'h2;
        hwdata = 32'h0;
    end

    // one single transfer; the caller stands just after a rising edge
    task automatic xfer(input logic wr, input logic [31:0] addr, input logic [31:0] wdata,
        output logic [31:0] rdata);
    begin
        hsel <= 1'h1;
        haddr <= addr;
        hwrite <= wr;
        htrans <= rsx_pkg::HTRANS_NONSEQ;
        do @(posedge clk); while (hready !== 1'h1);
        // address no longer qualified: scramble it so a stale decode shows up
        htrans <= 2'h0;
        haddr <= ~addr;
        hwrite <= ~wr;
        hwdata <= wr ? wdata : ~hwdata;
        do @(posedge clk); while (hready !== 1'h1);
        rdata = hrdata;
    end
    endtask
endmodule

//--- sim/rsx_alu_bench.sv
// self-checking bench for the rotate/sub/swap/xor datapath behind its bus
`timescale 1ns/10ps
module rsx_alu_bench;
    localparam logic [31:0] A_ACC = 32'(rsx_pkg::ACC_OFFS);
    localparam logic [31:0] A_ST = 32'(rsx_pkg::STATUS_OFFS);
    localparam logic [31:0] A_CMD = 32'(rsx_pkg::CMD_OFFS);
    localparam logic [31:0] A_DIR6 = 32'(rsx_pkg::DIR6_OFFS);
    localparam logic [31:0] A_DIR7 = 32'(rsx_pkg::DIR7_OFFS);
    logic clk = 1'h0; // core clock, 100 MHz
    logic sysRst = 1'h1; // held for the first 20 cycles
    logic hsel, hwrite, hready, hresp;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [31:0] haddr, hwdata, hrdata;
    logic [7:0] portDir6, portDir7; // direction register outputs
    int nErrors = 0; // mismatches seen
    int checked = 0; // comparisons made

    // free-running clock
    always #5 clk = ~clk;

    rsx_master i_mst (.clk(clk), .hready(hready), .hrdata(hrdata), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));
    rsx_alu i_dut (.clk(clk), .sys_rst(sysRst), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hreadyout(hready), .hrdata(hrdata), .hresp(hresp), .portDir6(portDir6),
        .portDir7(portDir7));

    // one comparison, reported at once
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    begin
        checked++;
        if (got !== exp)
        begin
            nErrors++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    end
    endtask

    // bus helpers: write, read and compare, issue one instruction
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        logic [31:0] unusedData;
        i_mst.xfer(1'h1, a, d, unusedData);
    endtask
    task automatic rdchk(input logic [31:0] a, input logic [31:0] exp);
        logic [31:0] v;
        i_mst.xfer(1'h0, a, 32'h0, v);
        chk(v, exp);
        chk({31'h0, hresp}, 32'h0);
    endtask
    task automatic exec(input logic [2:0] op, input logic d, input logic [4:0] f,
        input logic [7:0] k);
        wr(A_CMD, {8'h00, k, 7'h00, f, d, op});
    endtask
    function automatic logic [31:0] fa(input int n);
        return 32'(rsx_pkg::FILE_BASE) + 32'(n * 4);
    endfunction

    // reset values, an unmapped place and the do-nothing opcode
    task automatic t_reset;
    begin
        rdchk(A_ACC, 32'h0);
        rdchk(A_ST, 32'h0);
        rdchk(A_DIR6, 32'hFF);
        chk({24'h0, portDir7}, 32'hFF);
        wr(32'h40, 32'h55);
        rdchk(32'h40, 32'h0);
        exec(rsx_pkg::OP_NONE, 1'h1, 5'h00, 8'h00);
        rdchk(fa(0), 32'h0);
    end
    endtask

    // rotates through carry, other flags kept, both destinations, last register
    task automatic t_rot;
    begin
        wr(fa(5), 32'h81);
        wr(A_ST, 32'h6);
        exec(rsx_pkg::OP_ROTL, 1'h1, 5'h05, 8'h00);
        rdchk(fa(5), 32'h02);
        rdchk(A_ST, 32'h7);
        exec(rsx_pkg::OP_ROTL, 1'h0, 5'h05, 8'h00);
        rdchk(A_ACC, 32'h05);
        rdchk(fa(5), 32'h02);
        rdchk(A_ST, 32'h6);
        wr(fa(31), 32'h01);
        exec(rsx_pkg::OP_ROTR, 1'h1, 5'h1F, 8'h00);
        rdchk(fa(31), 32'h00);
        rdchk(A_ST, 32'h7);
        exec(rsx_pkg::OP_ROTR, 1'h0, 5'h1F, 8'h00);
        rdchk(A_ACC, 32'h80);
        rdchk(A_ST, 32'h6);
    end
    endtask

    // subtract corners: borrow, digit borrow, zero; then into the accumulator
    task automatic t_sub;
        logic [7:0] fv[4] = '{8'h10, 8'h10, 8'h10, 8'h35};
        logic [7:0] av[4] = '{8'h01, 8'h20, 8'h10, 8'h12};
        logic [7:0] rv[4] = '{8'h0F, 8'hF0, 8'h00, 8'h23};
        logic [2:0] sv[4] = '{3'h1, 3'h2, 3'h7, 3'h3};
    begin
        for (int i = 0; i < 4; i++)
        begin
            wr(A_ACC, {24'h0, av[i]});
            wr(fa(3), {24'h0, fv[i]});
            wr(A_ST, 32'h0);
            exec(rsx_pkg::OP_SUB, 1'h1, 5'h03, 8'h00);
            rdchk(fa(3), {24'h0, rv[i]});
            rdchk(A_ST, {29'h0, sv[i]});
            rdchk(A_ACC, {24'h0, av[i]});
        end
        exec(rsx_pkg::OP_SUB, 1'h0, 5'h03, 8'h00);
        rdchk(A_ACC, 32'h11);
        rdchk(A_ST, 32'h3);
    end
    endtask

    // nibble exchange both ways, flags left alone
    task automatic t_swap;
    begin
        wr(fa(0), 32'hA5);
        wr(A_ST, 32'h7);
        exec(rsx_pkg::OP_SWAP, 1'h0, 5'h00, 8'h00);
        rdchk(A_ACC, 32'h5A);
        rdchk(fa(0), 32'hA5);
        rdchk(A_ST, 32'h7);
        wr(A_ST, 32'h0);
        exec(rsx_pkg::OP_SWAP, 1'h1, 5'h00, 8'h00);
        rdchk(fa(0), 32'h5A);
        rdchk(A_ST, 32'h0);
    end
    endtask

    // direction loads for both operands and a refused operand
    task automatic t_dir;
    begin
        wr(A_ACC, 32'h3C);
        wr(A_ST, 32'h5);
        exec(rsx_pkg::OP_DIR, 1'h0, 5'h06, 8'h00);
        @(posedge clk);
        chk({24'h0, portDir6}, 32'h3C);
        chk({24'h0, portDir7}, 32'hFF);
        wr(A_ACC, 32'hC3);
        exec(rsx_pkg::OP_DIR, 1'h0, 5'h07, 8'h00);
        wr(A_ACC, 32'h00);
        exec(rsx_pkg::OP_DIR, 1'h0, 5'h05, 8'h00);
        rdchk(A_DIR6, 32'h3C);
        rdchk(A_DIR7, 32'hC3);
        rdchk(A_ST, 32'h5);
    end
    endtask

    // register and literal exclusive-or, zero flag only, literal ignores dest
    task automatic t_xor;
    begin
        wr(A_ACC, 32'hFF);
        wr(fa(7), 32'hFF);
        wr(A_ST, 32'h1);
        exec(rsx_pkg::OP_XORF, 1'h1, 5'h07, 8'h00);
        rdchk(fa(7), 32'h00);
        rdchk(A_ST, 32'h5);
        exec(rsx_pkg::OP_XORF, 1'h0, 5'h07, 8'h00);
        rdchk(A_ACC, 32'hFF);
        rdchk(A_ST, 32'h1);
        exec(rsx_pkg::OP_XORL, 1'h1, 5'h07, 8'hFF);
        rdchk(A_ACC, 32'h00);
        rdchk(fa(7), 32'h00);
        rdchk(A_ST, 32'h5);
        exec(rsx_pkg::OP_XORL, 1'h0, 5'h00, 8'h5A);
        exec(rsx_pkg::OP_XORL, 1'h0, 5'h00, 8'h00);
        rdchk(A_ACC, 32'h5A);
        rdchk(A_ST, 32'h1);
    end
    endtask

    // verdict and end of run
    task automatic end_of_test;
    begin
        $display("comparisons %0d, mismatches %0d", checked, nErrors);
        if (nErrors == 0 && checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    end
    endtask

    // main sequence
    initial
    begin
        repeat (20) @(posedge clk);
        sysRst <= 1'h0;
        t_reset();
        t_rot();
        t_sub();
        t_swap();
        t_dir();
        t_xor();
        end_of_test();
    end

    // watchdog, far beyond the few hundred cycles the tests need
    initial
    begin
        repeat (20000) @(posedge clk);
        nErrors++;
        end_of_test();
    end
endmodule
